// ===== logic/priority_shadow_defines.svh
`ifndef PRIORITY_SHADOW_DEFINES_SVH
`define PRIORITY_SHADOW_DEFINES_SVH

// byte offset of the shadow byte inside the virtual page
`define SHADOW_BYTE_OFFSET   64'h0000_0000_0000_0080
// page is 4 KByte aligned: low address bits forced to zero
`define PAGE_ALIGN_BITS      12
`define PAGE_ALIGN_MASK      64'hffff_ffff_ffff_f000
// shadow priority field and threshold field positions
`define SHADOW_PRIO_HI       7
`define SHADOW_PRIO_LO       4
`define THRESH_HI            3
`define THRESH_LO            0
// exit-reason codes
`define EXIT_REASON_EXT_INT  16'h0001
`define EXIT_REASON_PRIO     16'h0040
// exit interruption-information layout
`define INFO_VALID_BIT       31
`define INFO_VECTOR_HI       7
`define INFO_VECTOR_LO       0
// lowest vector used by external interrupts
`define VECTOR_MIN           8'h20
// configuration selects
`define CFG_SEL_PAGE         2'h0
`define CFG_SEL_THRESH       2'h1
`define CFG_SEL_SHADOW       2'h2
// reset values
`define RST_PAGE_ADDR        64'h0000_0000_0000_0000
`define RST_THRESHOLD        32'h0000_0000
`define RST_SHADOW           8'h00
`define RST_EXIT_INFO        32'h0000_0000

`endif

// ===== logic/priority_shadow_pkg.sv
package priority_shadow_pkg;

  typedef struct packed {
    logic use_priority_shadow;
    logic priority_read_exiting;
    logic priority_write_exiting;
    logic ext_int_exiting;
    logic host_int_flag;
    logic ack_on_exit;
  } exec_ctrl_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [3:0] level;
  } guest_req_t;

  typedef enum logic [1:0] {
    MODE_HOST  = 2'b00,
    MODE_GUEST = 2'b01,
    MODE_ACK   = 2'b10
  } mode_t;

  typedef struct packed {
    mode_t        mode;
    logic [63:0]  page_addr;
    logic [63:0]  shadow_addr;
    logic [31:0]  threshold;
    logic [7:0]   shadow;
    logic         if_flag;
    logic         exit_pulse;
    logic [15:0]  exit_reason;
    logic [31:0]  exit_info;
    logic         read_valid;
    logic [3:0]   read_data;
    logic         inta_req;
  } core_state_t;

endpackage : priority_shadow_pkg

// ===== logic/priority_compare.sv
`timescale 1ns/1ps
`default_nettype none

// four-bit priority against four-bit threshold
module priority_compare
  import priority_shadow_pkg::*;
#(
  parameter int WIDTH = 4
)(
  input  wire logic [WIDTH-1:0] level,
  input  wire logic [WIDTH-1:0] limit,
  output logic                  below
);

  assign below = (level < limit);

endmodule : priority_compare

`default_nettype wire

// ===== logic/priority_shadow_exit_logic.sv
// Contract
// RULE1: hold 64-bit page address, 4-KByte aligned
// RULE2: shadow is bits 7:4 of byte 128
// RULE3: exit when write drops below threshold
// RULE4: shadow read without exit when enabled
// RULE5: read exiting forces exit on reads
// RULE6: shadow write stored, exit if below
// RULE7: write exiting forces exit on writes
// RULE8: hypervisor sets both interrupt exit bits
// RULE9: every exit clears interrupt-enable flag
// RULE10: external interrupt exit reason is 1
// RULE11: acknowledge, capture vector before handover
// RULE12: hypervisor may re-enable interrupts itself
// RULE13: vectors are 8 bits, 20h to ffh
// RULE14: compare upper nibble against four-bit threshold
`timescale 1ns/1ps
`default_nettype none
`include "priority_shadow_defines.svh"

module priority_shadow_exit_logic
  import priority_shadow_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CLK_EN,
  input  wire exec_ctrl_t  EXEC_CTRL,
  input  wire guest_req_t  GUEST_REQ,
  input  wire logic        EXT_INT,
  input  wire logic        INTA_ACK,
  input  wire logic [7:0]  INTA_VECTOR,
  input  wire logic        VM_ENTRY,
  input  wire logic        IF_SET,
  input  wire logic        CFG_WR,
  input  wire logic [1:0]  CFG_SEL,
  input  wire logic [63:0] CFG_WDATA,
  output logic             IN_GUEST,
  output logic             READ_VALID,
  output logic [3:0]       READ_DATA,
  output logic             EXIT_PULSE,
  output logic [15:0]      EXIT_REASON,
  output logic [31:0]      EXIT_INFO,
  output logic             INTA_REQ,
  output logic             IF_FLAG,
  output logic [63:0]      PAGE_ADDR,
  output logic [63:0]      SHADOW_ADDR,
  output logic [31:0]      THRESHOLD,
  output logic [7:0]       SHADOW_BYTE
);

  ////////////////////////////////////////////////////////////////////////////
  core_state_t r;
  core_state_t next_r;
  logic        below;
  logic        ext_exit;
  logic        prio_exit;

  // RULE14: nibble against nibble
  priority_compare #(
    .WIDTH (4)
  ) i_priority_compare (
    .level (GUEST_REQ.level),
    .limit (r.threshold[`THRESH_HI:`THRESH_LO]),
    .below (below)
  );

  // RULE8: exit only when both pin controls are set
  assign ext_exit = (r.mode == MODE_GUEST) && EXT_INT
                    && EXEC_CTRL.ext_int_exiting && EXEC_CTRL.host_int_flag;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_r            = r;
    next_r.exit_pulse = 1'b0;
    next_r.read_valid = 1'b0;
    prio_exit         = 1'b0;
    case (r.mode)
      MODE_HOST:
      begin
        // RULE12: interrupts come back only by software
        if (IF_SET)
        begin
          next_r.if_flag = 1'b1;
        end
        if (CFG_WR)
        begin
          case (CFG_SEL)
            `CFG_SEL_PAGE:
            begin
              // RULE1: aligned page and derived shadow address
              next_r.page_addr   = CFG_WDATA & `PAGE_ALIGN_MASK;
              next_r.shadow_addr = (CFG_WDATA & `PAGE_ALIGN_MASK) | `SHADOW_BYTE_OFFSET;
            end
            `CFG_SEL_THRESH:
            begin
              next_r.threshold = CFG_WDATA[31:0];
            end
            `CFG_SEL_SHADOW:
            begin
              next_r.shadow = CFG_WDATA[7:0];
            end
            default:
            begin
              next_r.threshold = r.threshold;
            end
          endcase
        end
        if (VM_ENTRY)
        begin
          next_r.mode = MODE_GUEST;
        end
      end
      MODE_GUEST:
      begin
        // external interrupt takes priority over a same-cycle guest access
        if (ext_exit)
        begin
          // RULE9: mask interrupts on exit
          next_r.if_flag     = 1'b0;
          // RULE10: reason code for external interrupt
          next_r.exit_reason = `EXIT_REASON_EXT_INT;
          next_r.exit_info   = `RST_EXIT_INFO;
          if (EXEC_CTRL.ack_on_exit)
          begin
            // RULE11: acknowledge before handing over
            next_r.mode     = MODE_ACK;
            next_r.inta_req = 1'b1;
          end
          else
          begin
            next_r.mode       = MODE_HOST;
            next_r.exit_pulse = 1'b1;
          end
        end
        else if (GUEST_REQ.valid && !GUEST_REQ.write)
        begin
          // RULE5: read exiting overrides shadow use
          if (EXEC_CTRL.priority_read_exiting || !EXEC_CTRL.use_priority_shadow)
          begin
            prio_exit = 1'b1;
          end
          else
          begin
            // RULE4: read served from the shadow
            next_r.read_valid = 1'b1;
            next_r.read_data  = r.shadow[`SHADOW_PRIO_HI:`SHADOW_PRIO_LO];
          end
        end
        else if (GUEST_REQ.valid)
        begin
          // RULE7: write exiting overrides shadow use
          if (EXEC_CTRL.priority_write_exiting || !EXEC_CTRL.use_priority_shadow)
          begin
            prio_exit = 1'b1;
          end
          else
          begin
            // RULE2: upper nibble of the shadow byte, low nibble cleared
            // RULE6: store first, then exit when below
            next_r.shadow = {GUEST_REQ.level, 4'h0};
            // RULE3: fell below threshold
            prio_exit     = below;
          end
        end
        if (prio_exit)
        begin
          // RULE9: mask interrupts on exit
          next_r.if_flag     = 1'b0;
          next_r.exit_reason = `EXIT_REASON_PRIO;
          next_r.exit_info   = `RST_EXIT_INFO;
          next_r.exit_pulse  = 1'b1;
          next_r.mode        = MODE_HOST;
        end
      end
      MODE_ACK:
      begin
        // RULE13: only vectors 20h..ffh are accepted, others keep waiting
        if (INTA_ACK && (INTA_VECTOR >= `VECTOR_MIN))
        begin
          // RULE11: vector saved then control handed over
          next_r.inta_req                                  = 1'b0;
          next_r.exit_info                                 = `RST_EXIT_INFO;
          next_r.exit_info[`INFO_VALID_BIT]                = 1'b1;
          next_r.exit_info[`INFO_VECTOR_HI:`INFO_VECTOR_LO] = INTA_VECTOR;
          next_r.exit_pulse                                = 1'b1;
          next_r.mode                                      = MODE_HOST;
        end
      end
      default:
      begin
        next_r.mode = MODE_HOST;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      r.mode        <= MODE_HOST;
      r.page_addr   <= `RST_PAGE_ADDR;
      r.shadow_addr <= `SHADOW_BYTE_OFFSET;
      r.threshold   <= `RST_THRESHOLD;
      r.shadow      <= `RST_SHADOW;
      r.if_flag     <= 1'b0;
      r.exit_pulse  <= 1'b0;
      r.exit_reason <= 16'h0000;
      r.exit_info   <= `RST_EXIT_INFO;
      r.read_valid  <= 1'b0;
      r.read_data   <= 4'h0;
      r.inta_req    <= 1'b0;
    end
    else if (CLK_EN)
    begin
      r <= next_r;
    end
  end

  assign IN_GUEST    = (r.mode == MODE_GUEST);
  assign READ_VALID  = r.read_valid;
  assign READ_DATA   = r.read_data;
  assign EXIT_PULSE  = r.exit_pulse;
  assign EXIT_REASON = r.exit_reason;
  assign EXIT_INFO   = r.exit_info;
  assign INTA_REQ    = r.inta_req;
  assign IF_FLAG     = r.if_flag;
  assign PAGE_ADDR   = r.page_addr;
  assign SHADOW_ADDR = r.shadow_addr;
  assign THRESHOLD   = r.threshold;
  assign SHADOW_BYTE = r.shadow;

  ////////////////////////////////////////////////////////////////////////////
  // checks; frozen cycles (CLK_EN low) are excluded from every trigger except those of a_page_align, a_exit_masks and a_vector_range
  logic g_rd;
  logic g_wr;
  assign g_rd = CLK_EN && IN_GUEST && !ext_exit && GUEST_REQ.valid && !GUEST_REQ.write;
  assign g_wr = CLK_EN && IN_GUEST && !ext_exit && GUEST_REQ.valid && GUEST_REQ.write;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_ack_start;
    CLK_EN && ext_exit && EXEC_CTRL.ack_on_exit;
  endsequence
  sequence s_ack_done;
    CLK_EN && (r.mode == MODE_ACK) && INTA_ACK && (INTA_VECTOR >= `VECTOR_MIN);
  endsequence

  property p_page_align;
    (PAGE_ADDR[11:0] == 12'h000) && (SHADOW_ADDR == (PAGE_ADDR | `SHADOW_BYTE_OFFSET));
  endproperty
  a_page_align: assert property (p_page_align) else $error("page misaligned"); // RULE1

  property p_read_shadow;
    g_rd && EXEC_CTRL.use_priority_shadow && !EXEC_CTRL.priority_read_exiting
      |=> READ_VALID && !EXIT_PULSE && (READ_DATA == $past(SHADOW_BYTE[7:4]));
  endproperty
  a_read_shadow: assert property (p_read_shadow) else $error("shadow read wrong"); // RULE4

  property p_read_exit;
    g_rd && EXEC_CTRL.priority_read_exiting
      |=> EXIT_PULSE && !READ_VALID && (EXIT_REASON == `EXIT_REASON_PRIO);
  endproperty
  a_read_exit: assert property (p_read_exit) else $error("read did not exit"); // RULE5

  property p_write_store;
    g_wr && EXEC_CTRL.use_priority_shadow && !EXEC_CTRL.priority_write_exiting
      |=> (SHADOW_BYTE[7:4] == $past(GUEST_REQ.level)) && (EXIT_PULSE == $past(below));
  endproperty
  a_write_store: assert property (p_write_store) else $error("shadow write wrong"); // RULE6

  property p_write_below;
    g_wr && EXEC_CTRL.use_priority_shadow && !EXEC_CTRL.priority_write_exiting
      && (GUEST_REQ.level < THRESHOLD[3:0]) |=> EXIT_PULSE && !IN_GUEST;
  endproperty
  a_write_below: assert property (p_write_below) else $error("no exit below threshold"); // RULE3

  property p_write_exit;
    g_wr && EXEC_CTRL.priority_write_exiting
      |=> EXIT_PULSE && (SHADOW_BYTE == $past(SHADOW_BYTE));
  endproperty
  a_write_exit: assert property (p_write_exit) else $error("write did not exit"); // RULE7

  property p_exit_masks;
    EXIT_PULSE |-> !IF_FLAG && !IN_GUEST;
  endproperty
  a_exit_masks: assert property (p_exit_masks) else $error("flag left set on exit"); // RULE9

  property p_ext_reason;
    CLK_EN && ext_exit |=> (EXIT_REASON == `EXIT_REASON_EXT_INT) && !IF_FLAG;
  endproperty
  a_ext_reason: assert property (p_ext_reason) else $error("bad external reason"); // RULE10

  property p_ack_flow;
    s_ack_start |=> INTA_REQ && !EXIT_PULSE;
  endproperty
  a_ack_flow: assert property (p_ack_flow) else $error("ack not requested"); // RULE11

  property p_ack_done;
    s_ack_done |=> EXIT_PULSE && !INTA_REQ && (EXIT_INFO[7:0] == $past(INTA_VECTOR));
  endproperty
  a_ack_done: assert property (p_ack_done) else $error("vector not saved"); // RULE11

  property p_vector_range;
    EXIT_INFO[`INFO_VALID_BIT] |-> (EXIT_INFO[7:0] >= `VECTOR_MIN);
  endproperty
  a_vector_range: assert property (p_vector_range) else $error("vector out of range"); // RULE13

endmodule : priority_shadow_exit_logic

`default_nettype wire

// ===== tb/intc_model.sv
`timescale 1ns/1ps
`default_nettype none

// platform interrupt controller answering the acknowledge cycle
module intc_model
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       inta_req,
  input  wire logic [2:0] lag,
  input  wire logic       bad_first,
  input  wire logic [7:0] vec,
  output logic            ack,
  output logic [7:0]      vector
);
  logic [2:0] cnt;
  logic       go;

  // a bad vector lasts one cycle only, the good one holds until taken
  assign go = (cnt == lag) || (cnt >= lag + 3'h2);

  always @(negedge clk)
  begin
    if (rst || !inta_req)
    begin
      ack    <= 1'b0;
      cnt    <= 3'h0;
      vector <= ~vector;
    end
    else
    begin
      cnt    <= (cnt == 3'h7) ? cnt : cnt + 3'h1;
      ack    <= go;
      vector <= !go ? ~vector : (bad_first && cnt == lag) ? 8'h1f : vec;
    end
  end
endmodule : intc_model

`default_nettype wire

// ===== tb/priority_shadow_exit_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none

module priority_shadow_exit_logic_tb;
  import priority_shadow_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        en = 1'b1;
  exec_ctrl_t  ctrl = 6'h26;
  guest_req_t  req = '0;
  logic        ext_int = 1'b0;
  logic        vm_entry = 1'b0;
  logic        if_set = 1'b0;
  logic        cfg_wr = 1'b0;
  logic [1:0]  sel = 2'h0;
  logic [63:0] wdata = 64'h0;
  logic [2:0]  lag = 3'h0;
  logic        bad = 1'b0;
  logic        in_guest, rd_v, exit_p, inta_req, inta_ack, if_flag;
  logic [3:0]  rd_data;
  logic [15:0] reason;
  logic [31:0] info, thresh;
  logic [63:0] page, saddr;
  logic [7:0]  sbyte, ivec;
  int          err_total = 0;
  int          total_checks = 0;
  int          cycles = 0;

  priority_shadow_exit_logic i_priority_shadow_exit_logic (
    .SYS_CLK(clk), .SYS_RST(rst), .CLK_EN(en), .EXEC_CTRL(ctrl),
    .GUEST_REQ(req), .EXT_INT(ext_int), .INTA_ACK(inta_ack),
    .INTA_VECTOR(ivec), .VM_ENTRY(vm_entry), .IF_SET(if_set),
    .CFG_WR(cfg_wr), .CFG_SEL(sel), .CFG_WDATA(wdata),
    .IN_GUEST(in_guest), .READ_VALID(rd_v), .READ_DATA(rd_data),
    .EXIT_PULSE(exit_p), .EXIT_REASON(reason), .EXIT_INFO(info),
    .INTA_REQ(inta_req), .IF_FLAG(if_flag), .PAGE_ADDR(page),
    .SHADOW_ADDR(saddr), .THRESHOLD(thresh), .SHADOW_BYTE(sbyte));

  intc_model i_intc_model (
    .clk(clk), .rst(rst), .inta_req(inta_req), .lag(lag),
    .bad_first(bad), .vec(8'h41), .ack(inta_ack), .vector(ivec));

  always #50 clk = ~clk;

  //////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  // hang guard, the whole run needs well under a hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic cfg(input logic [1:0] s, input logic [63:0] d);
    sel = s;
    wdata = d;
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
    @(negedge clk);
  endtask : cfg

  // hypervisor re-enables interrupts, then enters the guest
  task automatic enter;
    if_set = 1'b1;
    @(negedge clk);
    if_set = 1'b0;
    vm_entry = 1'b1;
    @(negedge clk);
    vm_entry = 1'b0;
    chk("if_flag", 1, if_flag);
    chk("in_guest", 1, in_guest);
  endtask : enter

  task automatic acc(input logic w, input logic [3:0] l, input logic ex);
    req = '{1'b1, w, l};
    @(negedge clk);
    req = '0;
    chk("exit", ex, exit_p);
    chk("read_valid", !w && !ex, rd_v);
    if (ex)
      chk("reason", 16'h0040, reason);
    @(negedge clk);
  endtask : acc

  //////////////////////////////////////////////////////////////////
  task automatic t_cfg;
    chk("shadow_addr", 64'h80, saddr);
    cfg(2'h0, 64'h12345);
    chk("page", 64'h12000, page);
    chk("shadow_addr", 64'h12080, saddr);
    cfg(2'h1, 64'h5a5a_a5a5);
    chk("threshold", 32'h5a5a_a5a5, thresh);
    cfg(2'h2, 64'h90);
    chk("shadow", 8'h90, sbyte);
    // clock enable low must freeze every register, config included
    en = 1'b0;
    cfg(2'h2, 64'h11);
    chk("shadow_frozen", 8'h90, sbyte);
    en = 1'b1;
  endtask : t_cfg

  task automatic t_shadow;
    ctrl = 6'h26;
    enter();
    acc(1'b1, 4'h5, 1'b0);
    chk("shadow", 8'h50, sbyte);
    acc(1'b0, 4'h0, 1'b0);
    chk("read_data", 4'h5, rd_data);
    acc(1'b1, 4'h4, 1'b1);
    chk("shadow", 8'h40, sbyte);
    chk("if_flag", 0, if_flag);
    chk("in_guest", 0, in_guest);
    acc(1'b1, 4'h1, 1'b0);
    chk("shadow", 8'h40, sbyte);
  endtask : t_shadow

  task automatic t_exiting;
    ctrl = 6'h36;
    enter();
    acc(1'b0, 4'h0, 1'b1);
    ctrl = 6'h2e;
    enter();
    acc(1'b1, 4'h9, 1'b1);
    chk("shadow", 8'h40, sbyte);
  endtask : t_exiting

  task automatic t_ext(input logic a, input logic b, input logic [2:0] l);
    ctrl = a ? 6'h27 : 6'h26;
    bad = b;
    lag = l;
    enter();
    ext_int = 1'b1;
    @(negedge clk);
    ext_int = 1'b0;
    chk("reason", 16'h0001, reason);
    chk("if_flag", 0, if_flag);
    chk("inta_req", a, inta_req);
    if (a)
    begin
      for (int i = 0; i < 20 && exit_p !== 1'b1; i++)
        @(negedge clk);
      chk("info", 32'h8000_0041, info);
      chk("inta_req", 0, inta_req);
    end
    else
      chk("info", 0, info);
    chk("exit", 1, exit_p);
    @(negedge clk);
  endtask : t_ext

  initial
  begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_cfg();
    t_shadow();
    t_exiting();
    t_ext(1'b0, 1'b0, 3'h0);
    t_ext(1'b1, 1'b0, 3'h0);
    t_ext(1'b1, 1'b1, 3'h3);
    finish_test();
  end
endmodule : priority_shadow_exit_logic_tb

`default_nettype wire
